// ===== core/apms_pkg.sv
package apms_pkg;
  // register indices of the control page
  localparam logic [7:0] APMS_IDX_SLEEP_CTRL = 8'h02;
  localparam logic [7:0] APMS_IDX_IN_CH_EN = 8'h73;
  localparam logic [7:0] APMS_IDX_OUT_SLOT_EN = 8'h74;
  localparam logic [7:0] APMS_IDX_PWR_UP = 8'h75;
  localparam logic [7:0] APMS_IDX_PWR_STATUS = 8'h77;
  // field positions
  localparam int APMS_BIT_SLEEP_N = 0;
  localparam int APMS_BIT_SLEEP_DONE = 7;
  localparam int APMS_BIT_HW_SHDN = 6;
  localparam int APMS_BIT_ACTIVE = 5;
  localparam int APMS_BIT_ADC_PWR = 7;
  localparam int APMS_BIT_BIAS_PWR = 6;
  localparam int APMS_BIT_PLL_PWR = 5;
  // reset values
  localparam logic [7:0] APMS_RST_SLEEP_CTRL = 8'h00;
  localparam logic [7:0] APMS_RST_IN_CH_EN = 8'hC0;
  localparam logic [7:0] APMS_RST_OUT_SLOT_EN = 8'h00;
  localparam logic [7:0] APMS_RST_PWR_UP = 8'h00;
  localparam logic [7:0] APMS_ZERO = 8'h00;
  // timing
  localparam int APMS_CLK_HZ = 40000000;
  localparam int APMS_INIT_TIME_US = 1000;
  localparam int APMS_WAKE_TIME_US = 1000;
  localparam int APMS_RAMP_TIME_US = 6000;
  localparam int APMS_INIT_CYC = APMS_CLK_HZ / 1000000 * APMS_INIT_TIME_US;
  localparam int APMS_WAKE_CYC = APMS_CLK_HZ / 1000000 * APMS_WAKE_TIME_US;
  localparam int APMS_RAMP_CYC = APMS_CLK_HZ / 1000000 * APMS_RAMP_TIME_US;
  localparam int APMS_CNT_W = 20;

  typedef enum logic [2:0] {
    APMS_HW_SHDN = 3'b000,
    APMS_INIT = 3'b001,
    APMS_SLEEP = 3'b010,
    APMS_WAKE = 3'b011,
    APMS_ACTIVE = 3'b100,
    APMS_RAMP = 3'b101
  } apms_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } apms_req_t;

  typedef struct packed {
    logic adc;
    logic bias;
    logic pll;
  } apms_pwr_t;
endpackage

// ===== core/apms_seq.sv
`timescale 1ns/1ps
//Function
// - low shutdown pin holds hardware shutdown, idle
// - pin release: init registers, then sleep
// - sleep control write clears sleep, starts wake
// - input channel enable register gates conversion
// - output slot enable register gates slots
// - power up register drives analog power
// - active mode transmits TDM as slave
// - sleep write ramps volume, powers down
// - status register reports sleep; shutdown only to a read in the cycle the pin goes low
// - sleep keeps all register contents
// - shutdown pin low overrides any mode
// - leaving shutdown repeats full release sequence
// - sleep and wake repeat indefinitely
// - registers reachable over control interface
module apms_seq
  import apms_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int WORD = 32,
  parameter int INIT_CYC = APMS_INIT_CYC,
  parameter int WAKE_CYC = APMS_WAKE_CYC,
  parameter int RAMP_CYC = APMS_RAMP_CYC
)
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic SHUTDOWN_N_PIN,
  input wire apms_req_t CTRL_REQ,
  output logic [7:0] CTRL_RDATA,
  output logic CTRL_RVALID,
  input wire logic [CHANNELS*WORD-1:0] ADC_SAMPLES,
  output logic [CHANNELS-1:0] CH_CONVERT_EN,
  output apms_pwr_t PWR_CTRL,
  output logic [7:0] VOLUME_GAIN,
  input wire logic BIT_CLOCK,
  input wire logic FRAME_SYNC,
  output logic SDOUT,
  output logic SDOUT_OE,
  output logic [2:0] MODE
);
  localparam logic [APMS_CNT_W-1:0] INIT_LD = APMS_CNT_W'(INIT_CYC);
  localparam logic [APMS_CNT_W-1:0] WAKE_LD = APMS_CNT_W'(WAKE_CYC);
  localparam logic [APMS_CNT_W-1:0] RAMP_LD = APMS_CNT_W'(RAMP_CYC);
  localparam logic [7:0] VOL_FULL = 8'hFF;

  apms_state_t state_r, state_nxt;
  logic [7:0] sleep_control_reg_r;
  logic [7:0] input_channel_enable_reg_r;
  logic [7:0] output_slot_enable_reg_r;
  logic [7:0] power_up_control_reg_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [7:0] vol_r;
  logic t_load;
  logic [APMS_CNT_W-1:0] t_count;
  logic t_done;

  wire in_shdn = !SHUTDOWN_N_PIN;
  // register access is refused during shutdown and init
  wire regs_live = (state_r != APMS_HW_SHDN) && (state_r != APMS_INIT);
  wire wr_ok = CTRL_REQ.wr && regs_live;
  wire wr_sleep = wr_ok && (CTRL_REQ.addr == APMS_IDX_SLEEP_CTRL);
  wire wr_in = wr_ok && (CTRL_REQ.addr == APMS_IDX_IN_CH_EN);
  wire wr_out = wr_ok && (CTRL_REQ.addr == APMS_IDX_OUT_SLOT_EN);
  wire wr_pwr = wr_ok && (CTRL_REQ.addr == APMS_IDX_PWR_UP);
  wire wake_req = sleep_control_reg_r[APMS_BIT_SLEEP_N];
  wire active = (state_r == APMS_ACTIVE);
  wire sleep_done = (state_r == APMS_SLEEP);

  wire [7:0] status_val = {sleep_done, in_shdn, active, 5'h00};
  wire [7:0] rd_mux =
    (CTRL_REQ.addr == APMS_IDX_SLEEP_CTRL) ? sleep_control_reg_r :
    (CTRL_REQ.addr == APMS_IDX_IN_CH_EN) ? input_channel_enable_reg_r :
    (CTRL_REQ.addr == APMS_IDX_OUT_SLOT_EN) ? output_slot_enable_reg_r :
    (CTRL_REQ.addr == APMS_IDX_PWR_UP) ? power_up_control_reg_r :
    (CTRL_REQ.addr == APMS_IDX_PWR_STATUS) ? status_val : APMS_ZERO;

  always_comb
  begin
    state_nxt = state_r;
    t_load = 1'b0;
    t_count = INIT_LD;
    case (state_r)
      APMS_HW_SHDN:
        if (!in_shdn)
        begin
          state_nxt = APMS_INIT;
          t_load = 1'b1;
          t_count = INIT_LD;
        end
      APMS_INIT:
        if (t_done)
          state_nxt = APMS_SLEEP;
      APMS_SLEEP:
        if (wake_req)
        begin
          state_nxt = APMS_WAKE;
          t_load = 1'b1;
          t_count = WAKE_LD;
        end
      APMS_WAKE:
        if (!wake_req)
        begin
          state_nxt = APMS_RAMP;
          t_load = 1'b1;
          t_count = RAMP_LD;
        end
        else if (t_done)
          state_nxt = APMS_ACTIVE;
      APMS_ACTIVE:
        if (!wake_req)
        begin
          state_nxt = APMS_RAMP;
          t_load = 1'b1;
          t_count = RAMP_LD;
        end
      APMS_RAMP:
        if (t_done)
          state_nxt = APMS_SLEEP;
      default:
        state_nxt = APMS_HW_SHDN;
    endcase
    if (in_shdn)
    begin
      state_nxt = APMS_HW_SHDN;
      t_load = 1'b0;
    end
  end

  apms_timer #(
    .W(APMS_CNT_W)
  ) u_timer (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .load(t_load),
    .count(t_count),
    .done(t_done)
  );

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      state_r <= APMS_HW_SHDN;
    else
      state_r <= state_nxt;
  end

  // registers are reinitialised by init only; sleep leaves them alone
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sleep_control_reg_r <= APMS_RST_SLEEP_CTRL;
      input_channel_enable_reg_r <= APMS_RST_IN_CH_EN;
      output_slot_enable_reg_r <= APMS_RST_OUT_SLOT_EN;
      power_up_control_reg_r <= APMS_RST_PWR_UP;
    end
    else if (state_r == APMS_INIT)
    begin
      sleep_control_reg_r <= APMS_RST_SLEEP_CTRL;
      input_channel_enable_reg_r <= APMS_RST_IN_CH_EN;
      output_slot_enable_reg_r <= APMS_RST_OUT_SLOT_EN;
      power_up_control_reg_r <= APMS_RST_PWR_UP;
    end
    else
    begin
      if (wr_sleep)
        sleep_control_reg_r <= CTRL_REQ.wdata;
      if (wr_in)
        input_channel_enable_reg_r <= CTRL_REQ.wdata;
      if (wr_out)
        output_slot_enable_reg_r <= CTRL_REQ.wdata;
      if (wr_pwr)
        power_up_control_reg_r <= CTRL_REQ.wdata;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rdata_r <= APMS_ZERO;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= CTRL_REQ.rd && regs_live;
      if (CTRL_REQ.rd && regs_live)
        rdata_r <= rd_mux;
    end
  end

  // volume steps down by one per clock in ramp and holds at zero once it gets there
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      vol_r <= APMS_ZERO;
    else if (active)
      vol_r <= VOL_FULL;
    else if (state_r == APMS_RAMP)
    begin
      if (vol_r != APMS_ZERO)
        vol_r <= vol_r - 8'h01;
    end
    else
      vol_r <= APMS_ZERO;
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_ch
      assign CH_CONVERT_EN[g] = active && input_channel_enable_reg_r[7-g];
    end
  endgenerate

  logic [CHANNELS-1:0] slot_en;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_slot
      assign slot_en[g] = output_slot_enable_reg_r[7-g];
    end
  endgenerate

  wire pwr_on = active || (state_r == APMS_RAMP);
  assign PWR_CTRL.adc = pwr_on && power_up_control_reg_r[APMS_BIT_ADC_PWR];
  assign PWR_CTRL.bias = pwr_on && power_up_control_reg_r[APMS_BIT_BIAS_PWR];
  assign PWR_CTRL.pll = pwr_on && power_up_control_reg_r[APMS_BIT_PLL_PWR];

  // slave TDM transmitter; host owns both clocks
  apms_tdm_tx #(
    .SLOTS(CHANNELS),
    .WORD(WORD)
  ) u_tdm (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .enable(active),
    .slot_en(slot_en),
    .samples(ADC_SAMPLES),
    .bclk(BIT_CLOCK),
    .frame_sync(FRAME_SYNC),
    .sdout(SDOUT),
    .sdout_oe(SDOUT_OE)
  );

  assign CTRL_RDATA = rdata_r;
  assign CTRL_RVALID = rvalid_r;
  assign VOLUME_GAIN = vol_r;
  assign MODE = state_r;
endmodule // apms_seq

// ===== core/apms_tdm_tx.sv
`timescale 1ns/1ps
module apms_tdm_tx
  import apms_pkg::*;
#(
  parameter int SLOTS = 8,
  parameter int WORD = 32
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [SLOTS-1:0] slot_en,
  input wire logic [SLOTS*WORD-1:0] samples,
  input wire logic bclk,
  input wire logic frame_sync,
  output logic sdout,
  output logic sdout_oe
);
  localparam int BW = $clog2(SLOTS*WORD);
  localparam int SW = $clog2(SLOTS);
  localparam int WW = $clog2(WORD);
  logic bclk_d_r;
  logic frame_sync_seen_r;
  logic [BW-1:0] bit_r;
  logic [SLOTS*WORD-1:0] frame_r;
  logic sdout_r;
  logic oe_r;
  wire fall = bclk_d_r && !bclk;
  // the bit shifted at each later fall is the one after the bit now on the line
  wire [BW-1:0] nbit = bit_r + BW'(1);
  wire [SW-1:0] slot = nbit[BW-1:WW];
  wire [WW-1:0] pos = nbit[WW-1:0];
  wire [BW-1:0] idx = BW'((SLOTS-1-int'(slot))*WORD + (WORD-1-int'(pos)));
  // shift out on falling bit clock, slot 0 first, msb first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bclk_d_r <= 1'b0;
      frame_sync_seen_r <= 1'b0;
      bit_r <= '0;
      frame_r <= '0;
      sdout_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else
    begin
      bclk_d_r <= bclk;
      if (!enable)
      begin
        frame_sync_seen_r <= 1'b0;
        oe_r <= 1'b0;
      end
      else if (fall)
      begin
        if (frame_sync)
        begin
          frame_sync_seen_r <= 1'b1;
          frame_r <= samples;
          bit_r <= '0;
          sdout_r <= samples[SLOTS*WORD-1];
          oe_r <= slot_en[0];
        end
        else if (frame_sync_seen_r)
        begin
          bit_r <= nbit;
          sdout_r <= frame_r[idx];
          oe_r <= slot_en[slot];
        end
      end
    end
  end
  assign sdout = sdout_r;
  assign sdout_oe = oe_r;
endmodule // apms_tdm_tx

// ===== core/apms_timer.sv
`timescale 1ns/1ps
module apms_timer
  import apms_pkg::*;
#(
  parameter int W = APMS_CNT_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_r;
  logic run_r;
  // done pulses once the loaded count has fully elapsed
  assign done = run_r && (cnt_r == '0);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end
    else if (load)
    begin
      cnt_r <= count - W'(1);
      run_r <= 1'b1;
    end
    else if (done)
      run_r <= 1'b0;
    else if (run_r)
      cnt_r <= cnt_r - W'(1);
  end
endmodule // apms_timer

// ===== tb/apms_host_model.sv
`timescale 1ns/1ps
module apms_host_model
#(
  parameter int BITS = 32,
  parameter int HALF = 4
)
(
  input wire logic clk,
  input wire logic go,
  input wire logic sdout,
  input wire logic sdout_oe,
  output logic bclk,
  output logic frame_sync,
  output logic [BITS-1:0] rx_data,
  output logic [BITS-1:0] rx_oe,
  output logic busy
);
  // one frame per go; bit clock stands still between frames
  initial
  begin
    bclk = 1'b0;
    frame_sync = 1'b0;
    busy = 1'b0;
    rx_data = '0;
    rx_oe = '0;
    forever
    begin
      @(posedge clk iff go);
      #1;
      busy = 1'b1;
      frame_sync = 1'b1;
      bclk = 1'b1;
      repeat (HALF) @(posedge clk);
      #1 bclk = 1'b0;
      for (int i = BITS - 1; i >= 0; i--)
      begin
        repeat (HALF) @(posedge clk);
        #1 bclk = 1'b1;
        frame_sync = 1'b0;
        rx_data[i] = sdout;
        rx_oe[i] = sdout_oe;
        repeat (HALF) @(posedge clk);
        #1 bclk = 1'b0;
      end
      busy = 1'b0;
    end
  end
endmodule // apms_host_model

// ===== tb/apms_seq_asserts.sv
`timescale 1ns/1ps
module apms_seq_asserts
  import apms_pkg::*;
#(
  parameter int RAMP_CYC = APMS_RAMP_CYC
)
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic SHUTDOWN_N_PIN,
  input wire apms_req_t CTRL_REQ,
  input wire logic [7:0] CTRL_RDATA,
  input wire logic CTRL_RVALID,
  input wire apms_pwr_t PWR_CTRL,
  input wire logic [7:0] VOLUME_GAIN,
  input wire logic [2:0] MODE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);
  logic [19:0] ramp_cnt_r;
  logic [19:0] ramp_cnt_nxt;
  logic stat_rd;
  logic ctl_wr;
  assign stat_rd = CTRL_REQ.rd && CTRL_REQ.addr == APMS_IDX_PWR_STATUS;
  assign ctl_wr = CTRL_REQ.wr && CTRL_REQ.addr == APMS_IDX_SLEEP_CTRL && SHUTDOWN_N_PIN;
  assign ramp_cnt_nxt = (MODE == 3'h5) ? ramp_cnt_r + 20'h00001 : 20'h00000;
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      ramp_cnt_r <= 20'h00000;
    else
      ramp_cnt_r <= ramp_cnt_nxt;
  end
  shdn_force_a: assert property (!SHUTDOWN_N_PIN |-> ##[1:2] MODE == 3'h0)
    else $error("shutdown pin low did not force shutdown mode");
  init_entry_a: assert property (MODE == 3'h0 && SHUTDOWN_N_PIN |=> MODE == 3'h1)
    else $error("pin release did not start init");
  access_refused_a: assert property (CTRL_REQ.rd && MODE inside {3'h0, 3'h1} |=> !CTRL_RVALID)
    else $error("read answered in shutdown or init");
  read_answer_a: assert property (CTRL_REQ.rd && MODE > 3'h1 |=> CTRL_RVALID)
    else $error("accepted read not answered");
  sleep_flag_a: assert property (CTRL_RVALID && $past(stat_rd) |->
    CTRL_RDATA[7] == ($past(MODE) == 3'h2))
    else $error("sleep done flag wrong");
  wake_start_a: assert property (MODE == 3'h2 && ctl_wr && CTRL_REQ.wdata[0] |-> ##2 MODE == 3'h3)
    else $error("wake write did not start wake");
  sleep_entry_a: assert property (MODE == 3'h4 && ctl_wr && !CTRL_REQ.wdata[0] |-> ##2 MODE == 3'h5)
    else $error("sleep write did not start ramp");
  power_gate_a: assert property (MODE inside {3'h0, 3'h1, 3'h2, 3'h3} |-> PWR_CTRL == 3'h0)
    else $error("power on outside active");
  volume_full_a: assert property (MODE == 3'h4 && $past(MODE) == 3'h4 |-> VOLUME_GAIN == 8'hFF)
    else $error("volume not full in active");
  ramp_len_a: assert property (32'(ramp_cnt_r) <= RAMP_CYC + 2)
    else $error("ramp too long");
endmodule // apms_seq_asserts
bind apms_seq apms_seq_asserts #(.RAMP_CYC(RAMP_CYC)) i_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
  .SHUTDOWN_N_PIN(SHUTDOWN_N_PIN), .CTRL_REQ(CTRL_REQ), .CTRL_RDATA(CTRL_RDATA),
  .CTRL_RVALID(CTRL_RVALID), .PWR_CTRL(PWR_CTRL), .VOLUME_GAIN(VOLUME_GAIN), .MODE(MODE));

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import apms_pkg::*;
;
  localparam int IC = 20;
  localparam int WC = 20;
  localparam int RC = 300;
  logic SYS_CLK;
  logic RESETN;
  logic pin;
  apms_req_t req;
  logic [7:0] rdata;
  logic rvalid, sdout, oe, bclk, frame_sync, go, busy;
  logic [3:0] conv;
  apms_pwr_t pwr;
  logic [7:0] vol;
  logic [2:0] mode;
  logic [31:0] rx_d, rx_o;
  int bad_count, n_compared;
  apms_seq #(.CHANNELS(4), .WORD(8), .INIT_CYC(IC), .WAKE_CYC(WC), .RAMP_CYC(RC)) i_dut (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .SHUTDOWN_N_PIN(pin), .CTRL_REQ(req),
    .CTRL_RDATA(rdata), .CTRL_RVALID(rvalid), .ADC_SAMPLES(32'hA53C960F),
    .CH_CONVERT_EN(conv), .PWR_CTRL(pwr), .VOLUME_GAIN(vol), .BIT_CLOCK(bclk),
    .FRAME_SYNC(frame_sync), .SDOUT(sdout), .SDOUT_OE(oe), .MODE(mode));
  apms_host_model #(.BITS(32), .HALF(4)) i_host (.clk(SYS_CLK), .go(go), .sdout(sdout),
    .sdout_oe(oe), .bclk(bclk), .frame_sync(frame_sync), .rx_data(rx_d), .rx_oe(rx_o), .busy(busy));
  initial
  begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = {1'b1, 1'b0, a, d};
    cyc(1);
    req = '0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] k,
    input logic v);
    int n;
    n = 0;
    req = {1'b0, 1'b1, a, 8'h00};
    cyc(1);
    req = '0;
    while (rvalid !== 1'b1 && n < 3)
    begin
      cyc(1);
      n++;
    end
    chk(32'(rvalid), 32'(v), "read valid");
    if (v)
      chk(32'(rdata & k), 32'(e), "read data");
    cyc(1);
  endtask
  task automatic wm(input logic [2:0] m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim)
    begin
      cyc(1);
      n++;
    end
    chk(32'(mode), 32'(m), "mode");
  endtask
  initial
  begin
    #(25 * 20000);
    bad_count++;
    end_sim;
  end
  initial
  begin
    RESETN = 1'b0;
    pin = 1'b0;
    req = '0;
    go = 1'b0;
    bad_count = 0;
    n_compared = 0;
    cyc(8);
    RESETN = 1'b1;
    cyc(10);
    chk(32'(mode), 32'h0, "shutdown mode");
    rd(APMS_IDX_PWR_STATUS, 8'h00, 8'hFF, 1'b0);
    pin = 1'b1;
    wm(3'h1, 3);
    wm(3'h2, IC + 4);
    rd(APMS_IDX_PWR_STATUS, 8'h80, 8'hFF, 1'b1);
    rd(APMS_IDX_IN_CH_EN, 8'hC0, 8'hFF, 1'b1);
    rd(8'h10, 8'h00, 8'hFF, 1'b1);
    $display("test release done");
    wr(APMS_IDX_SLEEP_CTRL, 8'h01);
    wm(3'h4, WC + 4);
    wr(APMS_IDX_IN_CH_EN, 8'hA0);
    wr(APMS_IDX_OUT_SLOT_EN, 8'hA0);
    wr(APMS_IDX_PWR_UP, 8'hA0);
    chk(32'(conv), 32'h5, "convert enables");
    chk(32'(pwr), 32'h5, "power controls");
    wr(APMS_IDX_PWR_UP, 8'hE0);
    chk(32'(pwr), 32'h7, "power controls");
    chk(32'(vol), 32'hFF, "volume full");
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(270);
    chk(rx_o, 32'hFF00FF00, "slot enables");
    chk(rx_d & 32'hFF00FF00, 32'hA5009600, "frame data");
    $display("test active done");
    wr(APMS_IDX_SLEEP_CTRL, 8'h00);
    chk(32'(mode), 32'h5, "ramp mode");
    rd(APMS_IDX_PWR_STATUS, 8'h00, 8'h80, 1'b1);
    wm(3'h2, RC + 4);
    chk(32'(pwr), 32'h0, "powered down");
    chk(32'(vol), 32'h0, "volume down");
    rd(APMS_IDX_PWR_STATUS, 8'h80, 8'hFF, 1'b1);
    rd(APMS_IDX_IN_CH_EN, 8'hA0, 8'hFF, 1'b1);
    wr(APMS_IDX_SLEEP_CTRL, 8'h01);
    wm(3'h4, WC + 4);
    chk(32'(conv), 32'h5, "convert enables");
    $display("test sleep done");
    pin = 1'b0;
    cyc(2);
    chk(32'(mode), 32'h0, "shutdown mode");
    chk(32'(pwr), 32'h0, "powered down");
    pin = 1'b1;
    wm(3'h1, 3);
    wm(3'h2, IC + 4);
    rd(APMS_IDX_IN_CH_EN, 8'hC0, 8'hFF, 1'b1);
    $display("test shutdown done");
    end_sim;
  end
endmodule // testbench
